// ---- core/lpc_pkg.sv ----
// Notes on behaviour
// - eight-bit control register resets to 0x80
// - top control bit reads one, ignores writes
// - divider power switch turns divider on
// - divider off when stopped or standby
// - display enable runs controller, keeps registers
// - show bit selects RAM or blank data
// - frame clock select picks sub or system division
// - third duty frame runs four thirds faster
// - halted system clock darkens system-divided display
// - boost ties commons together at static, half
// - duty select sets duty and RAM mapping
// - expansion uses top four columns, start column
// - display RAM takes word and byte writes
// - disabled display drops strobes, holds serial data
// - standby floats all expansion pins
// - common level from data, polarity, duty
// - segment level from data, polarity, duty
// - standby withholds subclock, display stops
package lpc_pkg;
    localparam logic [7:0] LPC_CTRL_OFS = 8'h00;
    localparam logic [7:0] LPC_PFC_OFS = 8'h04;
    localparam logic [7:0] LPC_STAT_OFS = 8'h08;
    localparam logic [7:0] LPC_RAM_OFS = 8'h40;
    localparam int LPC_RAM_WORDS = 15;
    localparam int LPC_COMS = 4;
    localparam int LPC_RAM_COLS = 120;
    localparam int LPC_PANEL_COLS = 40;
    localparam int LPC_EXP_FIRST_PIN = 36;
    localparam logic [6:0] LPC_EXP_START_HI = 7'h24;
    localparam logic [6:0] LPC_EXP_START_LO = 7'h00;
    localparam logic [6:0] LPC_EXP_BITS = 7'h50;
    localparam logic [7:0] LPC_CTRL_RESET = 8'h80;
    localparam logic [7:0] LPC_PFC_RESET = 8'h00;
    localparam int LPC_CTRL_FIXED_BIT = 7;

    typedef struct packed {
        logic reserved_one;
        logic divider_power_switch;
        logic display_enable;
        logic show_ram_contents;
        logic [3:0] frame_clock_select;
    } lpc_ctrl_t;

    typedef struct packed {
        logic duty_select_high;
        logic duty_select_low;
        logic backplane_drive_boost;
        logic external_expansion_enable;
        logic [3:0] segment_driver_select;
    } lpc_pfc_t;

    typedef enum logic [1:0] {
        LPC_DUTY_STATIC = 2'h0,
        LPC_DUTY_HALF = 2'h1,
        LPC_DUTY_THIRD = 2'h2,
        LPC_DUTY_QUARTER = 2'h3
    } lpc_duty_t;

    typedef enum logic [1:0] {
        LPC_LVL_VSS = 2'h0,
        LPC_LVL_V1 = 2'h1,
        LPC_LVL_V2 = 2'h2,
        LPC_LVL_V3 = 2'h3
    } lpc_level_t;

    typedef enum logic [3:0] {
        LPC_EXP_IDLE = 4'h1,
        LPC_EXP_LOW = 4'h2,
        LPC_EXP_HIGH = 4'h4,
        LPC_EXP_LATCH = 4'h8
    } lpc_exp_state_t;

    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } lpc_avs_req_t;

    typedef struct packed {
        logic serial_out_line;
        logic expansion_latch_strobe;
        logic expansion_shift_strobe;
        logic polarity_toggle;
    } lpc_exp_pins_t;
endpackage

// ---- core/lpc_clk_div.sv ----
module lpc_clk_div (
    input wire logic clk,
    input wire logic rstn,
    input wire logic tick_in,
    input wire logic [3:0] exponent,
    output logic tick_out
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [7:0] mask;

    always_comb begin
        mask = 8'((9'h001 << exponent) - 9'h001);
        next_cnt = tick_in ? cnt + 8'h01 : cnt;
        tick_out = tick_in && ((cnt & mask) == mask);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt <= 8'h00;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule

// ---- core/lpc_level_enc.sv ----
module lpc_level_enc #(
    parameter bit IS_COMMON = 1'b0
) (
    input wire lpc_pkg::lpc_duty_t duty,
    input wire logic data,
    input wire logic polarity,
    output lpc_pkg::lpc_level_t level
);
    import lpc_pkg::*;

    always_comb begin
        if (data) begin
            if (IS_COMMON) begin
                level = polarity ? LPC_LVL_VSS : LPC_LVL_V1;
            end else begin
                level = polarity ? LPC_LVL_V1 : LPC_LVL_VSS;
            end
        end else if (IS_COMMON) begin
            case (duty)
                LPC_DUTY_STATIC: level = polarity ? LPC_LVL_VSS : LPC_LVL_V1;
                // v2 and v3 are strapped together at half duty
                LPC_DUTY_HALF: level = LPC_LVL_V2;
                default: level = polarity ? LPC_LVL_V2 : LPC_LVL_V3;
            endcase
        end else begin
            case (duty)
                LPC_DUTY_STATIC, LPC_DUTY_HALF: begin
                    level = polarity ? LPC_LVL_VSS : LPC_LVL_V1;
                end
                default: level = polarity ? LPC_LVL_V3 : LPC_LVL_V2;
            endcase
        end
    end
endmodule

// ---- core/lpc_top.sv ----
module lpc_top (
    input wire logic clk,
    input wire logic rstn,
    input wire lpc_pkg::lpc_avs_req_t avs,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic standby,
    input wire logic sys_clock_halted,
    input wire logic subclock,
    output logic divider_on,
    output lpc_pkg::lpc_level_t [lpc_pkg::LPC_COMS-1:0] com_level,
    output lpc_pkg::lpc_level_t [lpc_pkg::LPC_PANEL_COLS-1:0] seg_level,
    output logic [lpc_pkg::LPC_PANEL_COLS-1:0] seg_pin_enable,
    output lpc_pkg::lpc_exp_pins_t exp_pins,
    output logic exp_oe
);
    import lpc_pkg::*;

    lpc_ctrl_t ctrl, next_ctrl;
    lpc_pfc_t pfc, next_pfc;
    logic [31:0] ram [LPC_RAM_WORDS];
    logic [31:0] next_ram [LPC_RAM_WORDS];
    logic [31:0] next_readdata, status_word;
    logic next_waitrequest, ram_hit, bus_req;
    logic [7:0] ram_ofs;

    logic sub_meta, sub_sync, sub_prev, sub_edge;
    logic [3:0] ram_idx, sub_exp, sys_exp, low_groups;
    logic sub_tick, sys_tick, src_ok, running, lcd_tick;

    lpc_duty_t duty;
    logic [1:0] phase, next_phase, last_phase, com_idx;
    logic polarity, next_polarity, show_ram_contents_on, next_divider_on;
    logic [LPC_RAM_COLS*LPC_COMS-1:0] ram_flat;
    logic [LPC_COMS-1:0] com_data;
    logic [LPC_PANEL_COLS-1:0] seg_data;
    lpc_level_t [LPC_COMS-1:0] com_lvl, next_com_level;
    lpc_level_t [LPC_PANEL_COLS-1:0] seg_lvl, next_seg_level;
    logic [LPC_PANEL_COLS-1:0] next_seg_pin_enable;

    lpc_exp_state_t exp_state, next_exp_state;
    logic [6:0] bit_cnt, next_bit_cnt, exp_col;
    lpc_exp_pins_t next_exp_pins;
    logic next_exp_oe, exp_bit;
    logic [8:0] exp_idx;

    // register file and display RAM over the bus, one wait state per access
    assign bus_req = avs.read | avs.write;
    assign ram_ofs = avs.address - LPC_RAM_OFS;
    assign ram_idx = ram_ofs[5:2];
    assign ram_hit = (avs.address >= LPC_RAM_OFS) && (ram_idx < 4'(LPC_RAM_WORDS))
                     && (ram_ofs[7:6] == 2'h0);
    assign status_word = {26'h0, exp_state != LPC_EXP_IDLE, show_ram_contents_on, divider_on,
                          polarity, com_idx};

    always_comb begin
        next_ctrl = ctrl;
        next_pfc = pfc;
        next_ram = ram;
        next_readdata = avs_readdata;
        next_waitrequest = 1'b1;
        if (bus_req && avs_waitrequest) begin
            next_waitrequest = 1'b0;
            if (avs.address == LPC_CTRL_OFS) begin
                next_readdata = {24'h0, ctrl};
            end else if (avs.address == LPC_PFC_OFS) begin
                next_readdata = {24'h0, pfc};
            end else if (avs.address == LPC_STAT_OFS) begin
                next_readdata = status_word;
            end else if (ram_hit) begin
                next_readdata = ram[ram_idx];
            end else begin
                next_readdata = 32'h0;
            end
        end else if (avs.write && !avs_waitrequest) begin
            if (avs.address == LPC_CTRL_OFS) begin
                if (avs.byteenable[0]) begin
                    next_ctrl = lpc_ctrl_t'({1'b1, avs.writedata[6:0]});
                end
            end else if (avs.address == LPC_PFC_OFS) begin
                if (avs.byteenable[0]) begin
                    next_pfc = lpc_pfc_t'(avs.writedata[7:0]);
                end
            end else if (ram_hit) begin
                for (int b = 0; b < 4; b++) begin
                    if (avs.byteenable[b]) begin
                        next_ram[ram_idx][8*b +: 8] = avs.writedata[8*b +: 8];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl <= lpc_ctrl_t'(LPC_CTRL_RESET);
            pfc <= lpc_pfc_t'(LPC_PFC_RESET);
            avs_readdata <= 32'h0;
            avs_waitrequest <= 1'b1;
        end else begin
            ctrl <= next_ctrl;
            pfc <= next_pfc;
            avs_readdata <= next_readdata;
            avs_waitrequest <= next_waitrequest;
        end
    end

    // RAM holds its contents across reset, like ordinary RAM
    always_ff @(posedge clk) begin
        ram <= next_ram;
    end

    // subclock is a pin, so sync it before edge detection
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sub_meta <= 1'b0;
            sub_sync <= 1'b0;
            sub_prev <= 1'b0;
        end else begin
            sub_meta <= subclock;
            sub_sync <= sub_meta;
            sub_prev <= sub_sync;
        end
    end
    assign sub_edge = sub_sync & ~sub_prev;

    always_comb begin
        // bit 2 is ignored on the subclock side
        if (ctrl.frame_clock_select[1]) begin
            sub_exp = 4'h2;
        end else if (ctrl.frame_clock_select[0]) begin
            sub_exp = 4'h1;
        end else begin
            sub_exp = 4'h0;
        end
        sys_exp = {1'b0, ctrl.frame_clock_select[2:0]} + 4'h1;
    end

    lpc_clk_div u_sub_div (
        .clk(clk),
        .rstn(rstn),
        .tick_in(sub_edge & ~standby),
        .exponent(sub_exp),
        .tick_out(sub_tick)
    );

    lpc_clk_div u_sys_div (
        .clk(clk),
        .rstn(rstn),
        .tick_in(~sys_clock_halted),
        .exponent(sys_exp),
        .tick_out(sys_tick)
    );

    assign src_ok = ctrl.frame_clock_select[3] ? ~sys_clock_halted : ~standby;
    assign running = ctrl.display_enable & ~standby & src_ok;
    assign lcd_tick = running & (ctrl.frame_clock_select[3] ? sys_tick : sub_tick);

    // frame: four ticks per frame, three at third duty to give 4/3 rate
    assign duty = lpc_duty_t'({pfc.duty_select_high, pfc.duty_select_low});
    assign last_phase = (duty == LPC_DUTY_THIRD) ? 2'h2 : 2'h3;

    always_comb begin
        next_phase = phase;
        next_polarity = polarity;
        if (!running) begin
            next_phase = 2'h0;
        end else if (phase > last_phase) begin
            next_phase = 2'h0;
        end else if (lcd_tick) begin
            if (phase == last_phase) begin
                next_phase = 2'h0;
                next_polarity = ~polarity;
            end else begin
                next_phase = phase + 2'h1;
            end
        end
        case (duty)
            LPC_DUTY_STATIC: com_idx = 2'h0;
            LPC_DUTY_HALF: com_idx = {1'b0, phase[1]};
            default: com_idx = phase;
        endcase
    end

    always_comb begin
        for (int w = 0; w < LPC_RAM_WORDS; w++) begin
            ram_flat[32*w +: 32] = ram[w];
        end
    end

    always_comb begin
        for (int k = 0; k < LPC_COMS; k++) begin
            com_data[k] = (2'(k) == com_idx);
            if (pfc.backplane_drive_boost && duty == LPC_DUTY_STATIC) begin
                com_data[k] = 1'b1;
            end else if (pfc.backplane_drive_boost && duty == LPC_DUTY_HALF) begin
                com_data[k] = (2'(k / 2) == com_idx);
            end
        end
        for (int c = 0; c < LPC_PANEL_COLS; c++) begin
            seg_data[c] = ctrl.show_ram_contents
                          && ram_flat[LPC_COMS*c + int'(com_idx)];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < LPC_COMS; gi++) begin : g_com
            lpc_level_enc #(.IS_COMMON(1'b1)) u_enc (
                .duty(duty),
                .data(com_data[gi]),
                .polarity(polarity),
                .level(com_lvl[gi])
            );
        end
        for (gi = 0; gi < LPC_PANEL_COLS; gi++) begin : g_seg
            lpc_level_enc #(.IS_COMMON(1'b0)) u_enc (
                .duty(duty),
                .data(seg_data[gi]),
                .polarity(polarity),
                .level(seg_lvl[gi])
            );
        end
    endgenerate

    always_comb begin
        low_groups = pfc.segment_driver_select[3] ?
                     (4'h8 + {3'h0, pfc.segment_driver_select[0]}) :
                     {1'b0, pfc.segment_driver_select[2:0]};
        for (int c = 0; c < LPC_PANEL_COLS; c++) begin
            if (c >= LPC_EXP_FIRST_PIN) begin
                next_seg_pin_enable[c] = ~pfc.external_expansion_enable;
            end else begin
                next_seg_pin_enable[c] = (4'(c / 4) < low_groups);
            end
        end
        // a stopped panel is parked at vss so no dc builds up
        next_com_level = com_lvl;
        next_seg_level = seg_lvl;
        if (!show_ram_contents_on) begin
            next_com_level = '{default: LPC_LVL_VSS};
            next_seg_level = '{default: LPC_LVL_VSS};
        end
        next_divider_on = ctrl.divider_power_switch & ctrl.display_enable
                          & ~standby;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            phase <= 2'h0;
            polarity <= 1'b0;
            show_ram_contents_on <= 1'b0;
            com_level <= '{default: LPC_LVL_VSS};
            seg_level <= '{default: LPC_LVL_VSS};
            seg_pin_enable <= '0;
            divider_on <= 1'b0;
        end else begin
            phase <= next_phase;
            polarity <= next_polarity;
            show_ram_contents_on <= running;
            com_level <= next_com_level;
            seg_level <= next_seg_level;
            seg_pin_enable <= next_seg_pin_enable;
            divider_on <= next_divider_on;
        end
    end

    // serial expansion; a slot tick that comes mid-burst is skipped
    assign exp_col = bit_cnt + ((pfc.segment_driver_select == 4'h0) ?
                     LPC_EXP_START_LO : LPC_EXP_START_HI);
    assign exp_idx = {exp_col, 2'h0} + {7'h0, com_idx};
    assign exp_bit = ctrl.show_ram_contents && ram_flat[exp_idx];

    always_comb begin
        next_exp_state = exp_state;
        next_bit_cnt = bit_cnt;
        next_exp_pins = exp_pins;
        next_exp_oe = ~standby & pfc.external_expansion_enable;
        if (!ctrl.display_enable) begin
            next_exp_state = LPC_EXP_IDLE;
            next_exp_pins.expansion_latch_strobe = 1'b0;
            next_exp_pins.expansion_shift_strobe = 1'b0;
            next_exp_pins.polarity_toggle = 1'b0;
        end else begin
            next_exp_pins.polarity_toggle = polarity;
            next_exp_pins.expansion_latch_strobe = 1'b0;
            next_exp_pins.expansion_shift_strobe = 1'b0;
            case (exp_state)
                LPC_EXP_IDLE: begin
                    if (lcd_tick && pfc.external_expansion_enable) begin
                        next_exp_state = LPC_EXP_LOW;
                        next_bit_cnt = 7'h00;
                    end
                end
                LPC_EXP_LOW: begin
                    next_exp_pins.serial_out_line = exp_bit;
                    next_exp_state = LPC_EXP_HIGH;
                end
                LPC_EXP_HIGH: begin
                    next_exp_pins.expansion_shift_strobe = 1'b1;
                    if (bit_cnt == LPC_EXP_BITS - 7'h01) begin
                        next_exp_state = LPC_EXP_LATCH;
                    end else begin
                        next_bit_cnt = bit_cnt + 7'h01;
                        next_exp_state = LPC_EXP_LOW;
                    end
                end
                LPC_EXP_LATCH: begin
                    next_exp_pins.expansion_latch_strobe = 1'b1;
                    next_exp_state = LPC_EXP_IDLE;
                end
                default: next_exp_state = LPC_EXP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            exp_state <= LPC_EXP_IDLE;
            bit_cnt <= 7'h00;
            exp_pins <= '0;
            exp_oe <= 1'b0;
        end else begin
            exp_state <= next_exp_state;
            bit_cnt <= next_bit_cnt;
            exp_pins <= next_exp_pins;
            exp_oe <= next_exp_oe;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    ctrl_reset_a: assert property ($past(rstn) == 1'b0 |-> ctrl == LPC_CTRL_RESET)
        else $error("control register not at reset value");
    fixed_bit_a: assert property (ctrl[LPC_CTRL_FIXED_BIT])
        else $error("control bit 7 not one");
    divider_on_a: assert property (ctrl.divider_power_switch && ctrl.display_enable
        && !standby |=> divider_on)
        else $error("divider not switched on");
    divider_off_a: assert property (!ctrl.display_enable || standby |=> !divider_on)
        else $error("divider on while stopped");
    dark_stop_a: assert property (!running |=> ##1 com_level == {LPC_COMS{LPC_LVL_VSS}})
        else $error("commons driven while stopped");
    frame_flip_a: assert property (lcd_tick && phase == last_phase
        |=> polarity != $past(polarity))
        else $error("polarity did not toggle at frame end");
    third_wrap_a: assert property (duty == LPC_DUTY_THIRD && running |=> phase != 2'h3)
        else $error("third duty used a fourth slot");
    boost_tie_a: assert property (pfc.backplane_drive_boost && duty == LPC_DUTY_STATIC
        && show_ram_contents_on && $stable(pfc) |=> com_level[0] == com_level[3])
        else $error("boosted commons differ");
    strobe_idle_a: assert property (!ctrl.display_enable |=> !exp_pins.expansion_shift_strobe
        && !exp_pins.expansion_latch_strobe && !exp_pins.polarity_toggle
        && $stable(exp_pins.serial_out_line))
        else $error("expansion active while disabled");
    standby_float_a: assert property (standby |=> !exp_oe)
        else $error("expansion driven in standby");
    one_wait_a: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest ##1
        avs_waitrequest)
        else $error("bus answer not after one wait state");

    frame_end_c: cover property (lcd_tick && phase == last_phase);
    latch_c: cover property (exp_pins.expansion_latch_strobe);
    byte_write_c: cover property (avs.write && !avs_waitrequest && ram_hit
        && avs.byteenable == 4'h1);
    standby_c: cover property (show_ram_contents_on ##1 standby);
endmodule

// ---- dv/lpc_exp_model.sv ----
module lpc_exp_model (
    input wire logic clk,
    input wire lpc_pkg::lpc_exp_pins_t pins,
    input wire logic oe,
    output int last_count,
    output int bursts,
    output logic [1:0] head
);
    timeunit 1ns;
    timeprecision 1ns;
    import lpc_pkg::*;
    int cnt = 0;
    initial begin
        last_count = 0;
        bursts = 0;
        head = 2'h0;
    end
    // data is taken while the shift strobe is high, as a real expander would
    always @(posedge clk) begin
        if (oe && pins.expansion_shift_strobe) begin
            if (cnt < 2) begin
                head[cnt] <= pins.serial_out_line;
            end
            cnt <= cnt + 1;
        end
        if (oe && pins.expansion_latch_strobe) begin
            last_count <= cnt;
            bursts <= bursts + 1;
            cnt <= 0;
        end
    end
endmodule

// ---- dv/lpc_top_tb.sv ----
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module lpc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import lpc_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    lpc_avs_req_t avs = '0;
    logic standby = 1'b0;
    logic halted = 1'b0;
    logic subclock = 1'b0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic divider_on;
    lpc_level_t [LPC_COMS-1:0] com_level;
    lpc_level_t [LPC_PANEL_COLS-1:0] seg_level;
    logic [LPC_PANEL_COLS-1:0] seg_pin_enable;
    lpc_exp_pins_t exp_pins;
    logic exp_oe;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;
    int last_count;
    int bursts;
    logic [1:0] head;
    logic [31:0] d;
    logic m;

    lpc_top lpc_top_i (.clk(clk), .rstn(rstn), .avs(avs), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .standby(standby), .sys_clock_halted(halted),
        .subclock(subclock), .divider_on(divider_on), .com_level(com_level),
        .seg_level(seg_level), .seg_pin_enable(seg_pin_enable), .exp_pins(exp_pins),
        .exp_oe(exp_oe));
    lpc_exp_model lpc_exp_model_i (.clk(clk), .pins(exp_pins), .oe(exp_oe),
        .last_count(last_count), .bursts(bursts), .head(head));

    always #25 clk = ~clk;
    // odd start offset keeps subclock edges 7 ns clear of clk edges, at a fixed phase to clk
    initial begin
        #7;
        forever #200 subclock = ~subclock;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] be = 4'hF);
        avs <= '{a, 1'b0, 1'b1, wd, be};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs <= '0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] rdat);
        avs <= '{a, 1'b1, 1'b0, 32'h0, 4'hF};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        avs <= '0;
        @(posedge clk);
    endtask

    // settle 10 cycles past a polarity change so levels have landed
    task automatic wait_tog();
        logic m0;
        m0 = exp_pins.polarity_toggle;
        do @(posedge clk); while (exp_pins.polarity_toggle === m0);
        repeat (10) @(posedge clk);
        m = exp_pins.polarity_toggle;
    endtask

    // first two intervals after a setting change may be partial, so skip both
    task automatic frame_len(output int len);
        wait_tog();
        wait_tog();
        len = 10;
        do begin
            @(posedge clk);
            len++;
        end while (exp_pins.polarity_toggle === m);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(LPC_CTRL_OFS, d); `CHK(d, 32'h80)
        wr(LPC_CTRL_OFS, 32'h00);
        rd(LPC_CTRL_OFS, d); `CHK(d, 32'h80)
        wr(LPC_CTRL_OFS, 32'h7F);
        rd(LPC_CTRL_OFS, d); `CHK(d, 32'hFF)
        rd(8'h30, d); `CHK(d, 32'h0)
        wr(LPC_CTRL_OFS, 32'h40);
        repeat (3) @(posedge clk); `CHK(divider_on, 1'b0)
        wr(LPC_CTRL_OFS, 32'h60);
        repeat (3) @(posedge clk); `CHK(divider_on, 1'b1)
        wr(LPC_RAM_OFS, 32'h1);
        wr(LPC_RAM_OFS + 8'h4, 32'hA5A5_A5A5);
        wr(LPC_RAM_OFS + 8'h4, 32'h0000_3C00, 4'h2);
        rd(LPC_RAM_OFS + 8'h4, d); `CHK(d, 32'hA5A5_3CA5)
        wr(LPC_PFC_OFS, 32'h0F);
        wr(LPC_CTRL_OFS, 32'hFC);
        `CHK(seg_pin_enable, {LPC_PANEL_COLS{1'b1}})
        frame_len(n); `CHK(n, 128)
        for (int k = 0; k < 2; k++) begin
            wait_tog();
            `CHK(com_level[0], m ? LPC_LVL_VSS : LPC_LVL_V1)
            `CHK(seg_level[0], m ? LPC_LVL_V1 : LPC_LVL_VSS)
        end
        wr(LPC_PFC_OFS, 32'h2F);
        wait_tog(); `CHK(com_level[3], m ? LPC_LVL_VSS : LPC_LVL_V1)
        wr(LPC_CTRL_OFS, 32'hFF);
        frame_len(n); `CHK(n, 1024)
        wr(LPC_PFC_OFS, 32'h8F);
        frame_len(n); `CHK(n, 768)
        wr(LPC_PFC_OFS, 32'hCF);
        wr(LPC_CTRL_OFS, 32'hE2);
        frame_len(n); `CHK(n, 128)
        `CHK(seg_level[0], (!m) ? LPC_LVL_V3 : LPC_LVL_V2)
        wr(LPC_CTRL_OFS, 32'hE0);
        halted <= 1'b1;
        frame_len(n); `CHK(n, 32)
        wr(LPC_CTRL_OFS, 32'hEF);
        repeat (10) @(posedge clk); `CHK(com_level[0], LPC_LVL_VSS)
        halted <= 1'b0;
        wr(LPC_CTRL_OFS, 32'hE0);
        standby <= 1'b1;
        repeat (4) @(posedge clk); `CHK(divider_on, 1'b0)
        `CHK(com_level[0], LPC_LVL_VSS)
        standby <= 1'b0;
        wr(LPC_RAM_OFS, 32'hF);
        wr(LPC_PFC_OFS, 32'h70);
        wr(LPC_CTRL_OFS, 32'hFC);
        `CHK(seg_pin_enable, {LPC_PANEL_COLS{1'b0}})
        n = bursts + 2;
        while (bursts < n) @(posedge clk);
        `CHK(last_count, 80)
        `CHK(head, 2'b01)
        `CHK(exp_oe, 1'b1)
        `CHK(com_level[1], com_level[0])
        standby <= 1'b1;
        repeat (3) @(posedge clk); `CHK(exp_oe, 1'b0)
        standby <= 1'b0;
        repeat (40) @(posedge clk);
        wr(LPC_CTRL_OFS, 32'hDC);
        repeat (2) @(posedge clk);
        m = exp_pins.serial_out_line;
        `CHK(exp_pins[2:0], 3'h0)
        repeat (40) @(posedge clk); `CHK(exp_pins, {m, 3'h0})
        end_of_test();
    end
endmodule
